// ### bench/scc_props.sv
`timescale 1ns/1ns
`default_nettype none
`include "scc_map.svh"
module scc_props (
    // apb
    input wire logic clk,
    input wire logic rst,
    input wire logic [31:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // serial
    input wire logic serial_in_line,
    input wire logic serial_out_line
);
    logic acc;
    logic wr;
    logic rd;
    logic hit;
    logic [7:0] ctl_r;
    logic tdl_r;
    logic [1:0] age_r;
    logic [6:0] quiet_r;
    assign acc = psel && penable;
    assign wr = acc && pwrite && pstrb[0];
    assign rd = acc && !pwrite;
    assign hit = paddr inside {`SCC_CTRL_OFS, `SCC_OPT_OFS, `SCC_STAT_OFS,
        `SCC_TXD_OFS, `SCC_RXD_OFS, `SCC_BAUD_OFS};
    always_ff @(posedge clk)
        if (rst) ctl_r <= `SCC_CTRL_RST;
        else if (wr && paddr == `SCC_CTRL_OFS) ctl_r <= pwdata[7:0];
    always_ff @(posedge clk)
        if (rst) tdl_r <= 1'b0;
        else if (wr && paddr == `SCC_OPT_OFS) tdl_r <= pwdata[1];
    // cycles since the last control or option write
    always_ff @(posedge clk)
        if (rst || (wr && paddr inside {`SCC_CTRL_OFS, `SCC_OPT_OFS}))
            age_r <= 2'h0;
        else if (age_r != 2'h3) age_r <= age_r + 2'h1;
    // idle run length; only sound while a frame is shorter than 127 clocks
    always_ff @(posedge clk)
        if (rst || serial_out_line != !tdl_r) quiet_r <= 7'h00;
        else if (quiet_r != 7'h7f) quiet_r <= quiet_r + 7'h01;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    ready_high_a: assert property (pready)
        else $error("pready low");
    map_error_a: assert property (acc |-> pslverr == !hit)
        else $error("pslverr wrong");
    reset_idle_a: assert property ($fell(rst) |-> serial_out_line)
        else $error("line not idle after reset");
    off_idle_a: assert property (!ctl_r[7] && age_r > 2'h1 |->
        serial_out_line == !tdl_r) else $error("line not idle when off");
    tx_off_a: assert property (ctl_r[7:6] == 2'h2 && age_r > 2'h1 |->
        serial_out_line == !tdl_r) else $error("line moved, tx off");
    tx_start_a: assert property (wr && paddr == `SCC_TXD_OFS &&
        ctl_r[7:6] == 2'h3 && age_r == 2'h3 && quiet_r == 7'h7f |->
        ##3 (serial_out_line == tdl_r) [*2]) else $error("no start bit");
    ctl_read_a: assert property (rd && paddr == `SCC_CTRL_OFS |->
        prdata == {24'h00_0000, ctl_r}) else $error("control readback");
    zero_par_a: assert property (rd && paddr == `SCC_STAT_OFS &&
        ctl_r[3:2] == 2'h1 |-> !prdata[`SCC_STAT_PE])
        else $error("parity error in zero mode");
    stat_off_a: assert property (rd && paddr == `SCC_STAT_OFS &&
        !ctl_r[7] && age_r > 2'h1 |-> prdata == 32'h0000_0000)
        else $error("status kept while off");
    cover property (wr && paddr == `SCC_TXD_OFS && ctl_r[7:6] == 2'h3);
    cover property (rd && paddr == `SCC_STAT_OFS && prdata[`SCC_STAT_PE]);
    cover property (acc && pslverr);
endmodule : scc_props
bind scc_uart_control scc_props scc_props_inst (.clk(clk), .rst(rst),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_in_line(serial_in_line),
    .serial_out_line(serial_out_line));
`default_nettype wire

// ### bench/scc_remote_node.sv
`timescale 1ns/1ns
`default_nettype none
module scc_remote_node #(
    parameter int BAUD = 8
) (
    // clock
    input wire logic clk,
    // lines
    input wire logic line_in,
    input wire logic inv,
    output logic line_out
);
    logic [23:0] got;
    int frames;
    initial line_out = 1'b1;
    initial frames = 0;
    always begin
        @(negedge clk);
        if ((line_in ^ inv) === 1'b0) begin
            repeat (BAUD / 2) @(negedge clk);
            for (int i = 0; i < 24; i++) begin
                got[i] = line_in ^ inv;
                repeat (BAUD) @(negedge clk);
            end
            frames++;
        end
    end
    task automatic send(input logic [23:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            line_out <= bits[i];
            repeat (BAUD) @(posedge clk);
        end
        line_out <= 1'b1;
    endtask : send
endmodule : scc_remote_node
`default_nettype wire

// ### bench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "scc_map.svh"
module testbench;
    localparam int BAUD = 8;
    localparam logic [7:0] TXC [5] = '{8'h10, 8'h07, 8'h1a, 8'h0d, 8'h13};
    localparam logic [7:0] RXC [3] = '{8'h06, 8'h1a, 8'h1a};
    localparam logic [2:0] FLIP = 3'h5;
    localparam logic [2:0] PERR = 3'h4;
    localparam logic [2:0] FERR = 3'h2;
    logic clk;
    logic rst;
    logic [31:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rx_line;
    logic tx_line;
    logic inv;
    logic err;
    logic [7:0] c;
    logic [23:0] bits;
    int f;
    int n;
    int failures;
    int checked;
    scc_uart_control scc_uart_control_inst (.clk(clk), .rst(rst),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .serial_in_line(rx_line),
        .serial_out_line(tx_line));
    scc_remote_node #(.BAUD(BAUD)) scc_remote_node_inst (.clk(clk),
        .line_in(tx_line), .inv(inv), .line_out(rx_line));
    task automatic close_out();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : close_out
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic [31:0] a, input logic w,
        input logic [31:0] d, output logic [31:0] r);
        int k;
        @(posedge clk);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 64);
        if (k == 64) failures++;
        if (k == 64) close_out();
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        logic [31:0] r;
        apb(a, 1'b1, {24'h00_0000, d}, r);
    endtask : wr
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] r;
        apb(a, 1'b0, 32'h0000_0000, r);
        check(r, e);
    endtask : rd
    function automatic logic [23:0] frame2(input logic [7:0] a,
        input logic [7:0] b, input logic [7:0] m);
        logic [23:0] v;
        logic [7:0] d;
        int p;
        v = '1;
        p = 0;
        for (int i = 0; i < 2; i++) begin
            d = i ? b : a;
            v[p] = 1'b0;
            p++;
            for (int j = 0; j < 7 + m[1]; j++) begin
                v[p] = m[4] ? d[j] : d[6 + m[1] - j];
                p++;
            end
            if (m[3:2] != 2'h0) begin
                v[p] = m[3] & (^(d & {m[1], 7'h7f}) ^ ~m[2]);
                p++;
            end
            p += 1 + m[0];
        end
        return v;
    endfunction : frame2
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        rst = 1'b1;
        paddr = 32'h0000_0000;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0000_0000;
        pstrb = 4'hf;
        inv = 1'b0;
        failures = 0;
        checked = 0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        pstrb <= 4'he;
        wr(`SCC_CTRL_OFS, 8'h00);
        pstrb <= 4'hf;
        rd(`SCC_CTRL_OFS, 32'h0000_0010);
        rd(32'h0fff_fa40, 32'h0000_0000);
        check({31'h0000_0000, err}, 32'h0000_0001);
        wr(`SCC_BAUD_OFS, 8'(BAUD));
        $display("register test done");
        for (int k = 0; k < 5; k++) begin
            c = TXC[k];
            wr(`SCC_CTRL_OFS, c);
            if (k == 4) wr(`SCC_OPT_OFS, 8'h02);
            @(posedge clk);
            inv <= (k == 4);
            wr(`SCC_CTRL_OFS, c | 8'h80);
            wr(`SCC_CTRL_OFS, c | 8'hc0);
            repeat (130) @(posedge clk);
            f = scc_remote_node_inst.frames;
            wr(`SCC_TXD_OFS, 8'hb4 ^ c);
            wr(`SCC_TXD_OFS, 8'h3c + c);
            rd(`SCC_STAT_OFS, 32'h0000_0080);
            n = 0;
            while (scc_remote_node_inst.frames == f && n < 600) begin
                @(posedge clk);
                n++;
            end
            if (n == 600) failures++;
            if (n == 600) close_out();
            bits = frame2(8'hb4 ^ c, 8'h3c + c, c);
            check({8'h00, scc_remote_node_inst.got}, {8'h00, bits});
            wr(`SCC_CTRL_OFS, c | 8'h80);
            wr(`SCC_CTRL_OFS, c);
        end
        $display("transmit test done");
        for (int k = 0; k < 3; k++) begin
            c = RXC[k];
            wr(`SCC_CTRL_OFS, c);
            wr(`SCC_CTRL_OFS, c | 8'h80);
            wr(`SCC_CTRL_OFS, c | 8'ha0);
            repeat (4) @(posedge clk);
            bits = frame2(8'h5a + 8'(k), 8'h00, c);
            bits[9] = bits[9] ^ FLIP[k];
            // low stop bit on one frame to raise the framing flag
            bits[10] = !FERR[k];
            scc_remote_node_inst.send(bits, 11);
            rd(`SCC_STAT_OFS, {28'h000_0000, 1'b1, PERR[k], FERR[k], 1'b0});
            rd(`SCC_RXD_OFS, 32'h0000_005a + k);
            wr(`SCC_CTRL_OFS, c | 8'h80);
            wr(`SCC_CTRL_OFS, c);
            rd(`SCC_STAT_OFS, 32'h0000_0000);
        end
        $display("receive test done");
        close_out();
    end
endmodule : testbench
`default_nettype wire

// ### src/scc_map.svh
// Behaviour
// RQ1 - channel enable low disables the channel and holds all logic in reset
// RQ2 - channel disabled: serial output idles high, or low when inverted
// RQ3 - software sets channel enable before transmit enable, clears in reverse
// RQ4 - transmit restart: clear enable, wait two clocks, set again
// RQ5 - transmitter runs only two clocks after transmit enable with channel on
// RQ6 - software sets channel enable before receive enable, clears in reverse
// RQ7 - receive restart: clear enable, wait two clocks, set again
// RQ8 - receiver active two clocks after enable; earlier start bits ignored
// RQ9 - bit order 0 sends msb first, 1 lsb first
// RQ10 - parity field: none, zero, odd, even generated and checked
// RQ11 - zero parity mode never checks parity nor sets parity error
// RQ12 - software selects no parity for lin framing
// RQ13 - character length 0 gives seven data bits, 1 gives eight
// RQ14 - stop length 0 appends one stop bit, 1 appends two
// RQ15 - software changes frame fields only when disabled or both idle
// RQ16 - control register byte accessible, resets with only bit order set
// RQ17 - invert settings flip the serial output and sampled input lines
`ifndef SCC_MAP_SVH
`define SCC_MAP_SVH

`define SCC_CTRL_OFS 32'h0fff_fa00
`define SCC_OPT_OFS 32'h0fff_fa04
`define SCC_STAT_OFS 32'h0fff_fa08
`define SCC_TXD_OFS 32'h0fff_fa0c
`define SCC_RXD_OFS 32'h0fff_fa10
`define SCC_BAUD_OFS 32'h0fff_fa14

`define SCC_CTRL_PWR 7
`define SCC_CTRL_TXE 6
`define SCC_CTRL_RXE 5
`define SCC_CTRL_DIR 4
`define SCC_CTRL_PS1 3
`define SCC_CTRL_PS0 2
`define SCC_CTRL_CL 1
`define SCC_CTRL_SL 0

`define SCC_OPT_TDL 1
`define SCC_OPT_RDL 0

`define SCC_STAT_TSF 7
`define SCC_STAT_RXF 3
`define SCC_STAT_PE 2
`define SCC_STAT_FE 1
`define SCC_STAT_OVE 0

`define SCC_CTRL_RST 8'h10
`define SCC_OPT_RST 2'h0
`define SCC_BAUD_RST 16'h0364
`define SCC_EN_LATENCY 2

`endif

// ### src/scc_pkg.sv
package scc_pkg;

    typedef enum logic {
        TX_IDLE,
        TX_SHIFT
    } scc_tx_state_type;

    typedef enum logic {
        RX_IDLE,
        RX_BUSY
    } scc_rx_state_type;

endpackage : scc_pkg

// ### src/scc_uart_control.sv
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "scc_map.svh"

module scc_uart_control #(
    parameter logic [15:0] BAUD_DIV_RESET = `SCC_BAUD_RST
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // apb slave
    input wire logic [31:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial lines
    input wire logic serial_in_line,
    output logic serial_out_line
);

    // sequence order: reverses data for msb first, involution
    function automatic logic [7:0] scc_order(input logic [7:0] d,
                                             input logic cl,
                                             input logic msb);
        logic [7:0] r;
        r = {cl & d[7], d[6:0]};
        if (msb && cl) begin
            for (int i = 0; i < 8; i++) begin
                r[i] = d[7 - i];
            end
        end else if (msb) begin
            r[7] = 1'b0;
            for (int i = 0; i < 7; i++) begin
                r[i] = d[6 - i];
            end
        end
        return r;
    endfunction : scc_order

    function automatic logic scc_parity(input logic [7:0] d,
                                        input logic [1:0] ps);
        logic p;
        p = 1'b0;
        if (ps == 2'b10) begin
            p = ~^d;
        end else if (ps == 2'b11) begin
            p = ^d;
        end
        return p;
    endfunction : scc_parity

    function automatic logic scc_hit(input logic [31:0] a);
        return (a == `SCC_CTRL_OFS) || (a == `SCC_OPT_OFS) ||
               (a == `SCC_STAT_OFS) || (a == `SCC_TXD_OFS) ||
               (a == `SCC_RXD_OFS) || (a == `SCC_BAUD_OFS);
    endfunction : scc_hit

    logic [7:0] ctrl_r;
    logic [1:0] opt_r;
    logic [15:0] baud_r;
    logic [7:0] txd_r;
    logic tx_pend_r;
    logic [7:0] rxd_r;
    logic rxf_r;
    logic pe_r;
    logic fe_r;
    logic ove_r;
    logic [31:0] prdata_r;
    logic [1:0] txe_sr_r;
    logic [1:0] rxe_sr_r;
    logic rx_s1_r;
    logic rx_s2_r;
    logic rx_prev_r;
    logic serial_out_r;
    scc_pkg::scc_tx_state_type tx_state_r;
    logic [11:0] tx_frame_r;
    logic [3:0] tx_left_r;
    logic [15:0] tx_cnt_r;
    scc_pkg::scc_rx_state_type rx_state_r;
    logic [15:0] rx_cnt_r;
    logic [3:0] rx_idx_r;
    logic [7:0] rx_seq_r;
    logic rx_par_r;

    logic pwr;
    logic cl;
    logic [1:0] ps;
    logic par_on;
    logic [3:0] nd;
    logic access;
    logic wr_en;
    logic rd_en;
    logic tx_on;
    logic rx_on;
    logic tx_load;
    logic rx_bit;
    logic rx_tick;
    logic rx_done;
    logic [7:0] rx_data;
    logic [3:0] rx_stop_idx;
    logic stat_wr;
    logic [11:0] tx_build;
    logic [3:0] tx_len;
    logic [7:0] tx_seq;

    assign pwr = ctrl_r[`SCC_CTRL_PWR];
    assign cl = ctrl_r[`SCC_CTRL_CL];
    assign ps = {ctrl_r[`SCC_CTRL_PS1], ctrl_r[`SCC_CTRL_PS0]};
    assign par_on = ps != 2'b00;
    // RQ13 seven or eight data bits
    assign nd = cl ? 4'd8 : 4'd7;

    // zero wait state: read data is latched in the setup cycle
    assign access = psel & penable;
    assign wr_en = access & pwrite & pstrb[0] & scc_hit(paddr);
    assign rd_en = access & ~pwrite;
    assign pready = 1'b1;
    assign pslverr = access & ~scc_hit(paddr);
    assign prdata = prdata_r;
    assign serial_out_line = serial_out_r;
    assign stat_wr = wr_en & (paddr == `SCC_STAT_OFS);

    // RQ16 byte written control, reset to bit order only
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_r <= `SCC_CTRL_RST;
            opt_r <= `SCC_OPT_RST;
            baud_r <= BAUD_DIV_RESET;
        end else if (wr_en) begin
            if (paddr == `SCC_CTRL_OFS) begin
                ctrl_r <= pwdata[7:0];
            end
            if (paddr == `SCC_OPT_OFS) begin
                opt_r <= pwdata[1:0];
            end
            if (paddr == `SCC_BAUD_OFS && (pstrb[1] || 1'b1)) begin
                baud_r <= {pstrb[1] ? pwdata[15:8] : baud_r[15:8],
                           pwdata[7:0]};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prdata_r <= 32'h0000_0000;
        end else if (psel & ~penable & ~pwrite) begin
            case (paddr)
                `SCC_CTRL_OFS: prdata_r <= {24'h00_0000, ctrl_r};
                `SCC_OPT_OFS: prdata_r <= {30'h0000_0000, opt_r};
                `SCC_STAT_OFS: prdata_r <= {24'h00_0000, tx_state_r !=
                    scc_pkg::TX_IDLE || tx_pend_r, 3'h0, rxf_r, pe_r,
                    fe_r, ove_r};
                `SCC_TXD_OFS: prdata_r <= {24'h00_0000, txd_r};
                `SCC_RXD_OFS: prdata_r <= {24'h00_0000, rxd_r};
                `SCC_BAUD_OFS: prdata_r <= {16'h0000, baud_r};
                default: prdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // RQ5 two clock enable latency
    always_ff @(posedge clk) begin
        if (rst) begin
            txe_sr_r <= 2'h0;
            rxe_sr_r <= 2'h0;
        end else begin
            txe_sr_r <= {txe_sr_r[0], pwr & ctrl_r[`SCC_CTRL_TXE]};
            rxe_sr_r <= {rxe_sr_r[0], pwr & ctrl_r[`SCC_CTRL_RXE]};
        end
    end

    // RQ1 channel off gates both units into reset
    assign tx_on = pwr & ctrl_r[`SCC_CTRL_TXE] & txe_sr_r[`SCC_EN_LATENCY-1];
    // RQ8 receiver held off until latency passes
    assign rx_on = pwr & ctrl_r[`SCC_CTRL_RXE] & rxe_sr_r[`SCC_EN_LATENCY-1];

    // transmit frame: start, data, parity, stops; lsb of vector goes first
    always_comb begin
        // RQ9 bit order
        tx_seq = scc_order(txd_r, cl, ~ctrl_r[`SCC_CTRL_DIR]);
        tx_build = 12'hfff;
        tx_build[0] = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (4'(i) < nd) begin
                tx_build[i + 1] = tx_seq[i];
            end
        end
        // RQ10 parity bit generation
        if (par_on) begin
            tx_build[nd + 4'd1] = scc_parity({cl & txd_r[7], txd_r[6:0]}, ps);
        end
        // RQ14 one or two stop bits
        tx_len = nd + 4'd2 + {3'h0, par_on} + {3'h0, ctrl_r[`SCC_CTRL_SL]};
    end

    assign tx_load = tx_on & (tx_state_r == scc_pkg::TX_IDLE) & tx_pend_r;

    // data write while busy replaces the pending byte
    always_ff @(posedge clk) begin
        if (rst || !tx_on) begin
            tx_pend_r <= 1'b0;
            txd_r <= 8'h00;
        end else if (wr_en && paddr == `SCC_TXD_OFS) begin
            tx_pend_r <= 1'b1;
            txd_r <= pwdata[7:0];
        end else if (tx_load) begin
            tx_pend_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || !tx_on) begin
            tx_state_r <= scc_pkg::TX_IDLE;
            tx_frame_r <= 12'hfff;
            tx_left_r <= 4'h0;
            tx_cnt_r <= 16'h0000;
        end else begin
            case (tx_state_r)
                scc_pkg::TX_IDLE: begin
                    if (tx_pend_r) begin
                        tx_frame_r <= tx_build;
                        tx_left_r <= tx_len;
                        tx_cnt_r <= 16'h0000;
                        tx_state_r <= scc_pkg::TX_SHIFT;
                    end
                end
                scc_pkg::TX_SHIFT: begin
                    if (tx_cnt_r >= baud_r - 16'h0001) begin
                        tx_cnt_r <= 16'h0000;
                        tx_frame_r <= {1'b1, tx_frame_r[11:1]};
                        tx_left_r <= tx_left_r - 4'h1;
                        if (tx_left_r == 4'h1) begin
                            tx_state_r <= scc_pkg::TX_IDLE;
                        end
                    end else begin
                        tx_cnt_r <= tx_cnt_r + 16'h0001;
                    end
                end
                default: tx_state_r <= scc_pkg::TX_IDLE;
            endcase
        end
    end

    // RQ2 idle level when channel off, then RQ17 output inversion
    always_ff @(posedge clk) begin
        if (rst) begin
            serial_out_r <= 1'b1;
        end else begin
            serial_out_r <= (pwr ? tx_frame_r[0] : 1'b1) ^
                            opt_r[`SCC_OPT_TDL];
        end
    end

    // input pin crosses in through two flops
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_s1_r <= 1'b1;
            rx_s2_r <= 1'b1;
            rx_prev_r <= 1'b1;
        end else begin
            rx_s1_r <= serial_in_line;
            rx_s2_r <= rx_s1_r;
            rx_prev_r <= rx_bit;
        end
    end

    // RQ17 input inversion
    assign rx_bit = rx_s2_r ^ opt_r[`SCC_OPT_RDL];
    assign rx_tick = (rx_state_r == scc_pkg::RX_BUSY) && (rx_cnt_r == 16'h0000);
    assign rx_stop_idx = nd + 4'd1 + {3'h0, par_on};
    assign rx_done = rx_tick && (rx_idx_r == rx_stop_idx);
    assign rx_data = scc_order(rx_seq_r, cl, ~ctrl_r[`SCC_CTRL_DIR]);

    // only the first stop bit is sampled
    always_ff @(posedge clk) begin
        if (rst || !rx_on) begin
            rx_state_r <= scc_pkg::RX_IDLE;
            rx_cnt_r <= 16'h0000;
            rx_idx_r <= 4'h0;
            rx_seq_r <= 8'h00;
            rx_par_r <= 1'b0;
        end else begin
            case (rx_state_r)
                scc_pkg::RX_IDLE: begin
                    // RQ8 start edge seen only once active
                    if (rx_prev_r && !rx_bit) begin
                        rx_cnt_r <= {1'b0, baud_r[15:1]};
                        rx_idx_r <= 4'h0;
                        rx_seq_r <= 8'h00;
                        rx_state_r <= scc_pkg::RX_BUSY;
                    end
                end
                scc_pkg::RX_BUSY: begin
                    if (rx_cnt_r != 16'h0000) begin
                        rx_cnt_r <= rx_cnt_r - 16'h0001;
                    end else begin
                        rx_cnt_r <= baud_r - 16'h0001;
                        rx_idx_r <= rx_idx_r + 4'h1;
                        if (rx_idx_r == 4'h0 && rx_bit) begin
                            // glitch, not a start bit
                            rx_state_r <= scc_pkg::RX_IDLE;
                        end else if (rx_idx_r == rx_stop_idx) begin
                            rx_state_r <= scc_pkg::RX_IDLE;
                        end else if (rx_idx_r != 4'h0 && rx_idx_r <= nd) begin
                            rx_seq_r[3'(rx_idx_r - 4'h1)] <= rx_bit;
                        end else if (rx_idx_r != 4'h0) begin
                            rx_par_r <= rx_bit;
                        end
                    end
                end
                default: rx_state_r <= scc_pkg::RX_IDLE;
            endcase
        end
    end

    // receive buffer; read of the data register empties it
    always_ff @(posedge clk) begin
        if (rst || !rx_on) begin
            rxd_r <= 8'h00;
            rxf_r <= 1'b0;
        end else if (rx_done) begin
            rxd_r <= rx_data;
            rxf_r <= 1'b1;
        end else if (rd_en && paddr == `SCC_RXD_OFS) begin
            rxf_r <= 1'b0;
        end
    end

    // error flags: set wins, writing 0 clears, writing 1 keeps
    always_ff @(posedge clk) begin
        if (rst || !rx_on) begin
            pe_r <= 1'b0;
            fe_r <= 1'b0;
            ove_r <= 1'b0;
        end else begin
            // RQ11 only odd and even modes check parity
            if (rx_done && ps[1] && rx_par_r != scc_parity(rx_data, ps)) begin
                pe_r <= 1'b1;
            end else if (stat_wr && !pwdata[`SCC_STAT_PE]) begin
                pe_r <= 1'b0;
            end
            if (rx_done && !rx_bit) begin
                fe_r <= 1'b1;
            end else if (stat_wr && !pwdata[`SCC_STAT_FE]) begin
                fe_r <= 1'b0;
            end
            if (rx_done && rxf_r) begin
                ove_r <= 1'b1;
            end else if (stat_wr && !pwdata[`SCC_STAT_OVE]) begin
                ove_r <= 1'b0;
            end
        end
    end

endmodule : scc_uart_control
`default_nettype wire
